// ===== shared/fieldbus_status_config_regs.vh
// Purpose: Offsets, field positions and reset values of the status/config bank
// Assumes: 12-bit register address, byte-wide data
// Notes:   Two-byte registers put the low byte at the base offset
`ifndef FIELDBUS_STATUS_CONFIG_REGS_VH
`define FIELDBUS_STATUS_CONFIG_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ERROR_IRQ_STATUS_OFS   12'h007
`define COMM_IRQ_MASK_OFS      12'h008
`define ADDR_IRQ_MASK_OFS      12'h009
`define TIMER_IRQ_MASK_OFS     12'h00a
`define ERROR_IRQ_MASK_OFS     12'h00b
`define TX_BYTE_COUNT_OFS      12'h00c
`define TX_BUFFER_POINTER_OFS  12'h00e
`define RX_BUFFER_POINTER_OFS  12'h012
`define LOOKUP_POINTER_OFS     12'h016
`define HIGH_LINK_TABLE_OFS    12'h018
`define FRAME_CONTROL_OFS      12'h018
`define FRAME_TYPE_CODE_OFS    12'h019
`define STATION_ID_OFS         12'h01b
`define COMM_STATUS_OFS        12'h01c
`define ADDR_RECOG_STATUS_OFS  12'h01d

// ------------------------------------------------------------
// Error status field positions
// ------------------------------------------------------------
`define JABBER_BIT             6
`define TX_START_EMPTY_BIT     5
`define CARRIER_LOSS_BIT       4
`define OVERLENGTH_BIT         3
`define LINE_CODE_BIT          2
`define MISSING_END_BIT        1
`define MISSING_START_BIT      0
`define ERROR_FLAG_MSB         6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MASK_RST               8'h00
`define POINTER_RST            14'h0000
`define STATION_ID_RST         8'h00
`define ERROR_STATUS_RST       7'h00
`define FRAME_CONTROL_RST      8'h00
`define FRAME_CODE_RST         5'h00
`define UNMAPPED_READ          8'h00

`endif

// ===== rtl/pin_sync.v
// Purpose: Two-stage synchroniser for host bus pins
// Assumes: Pins are quasi-static around the strobes
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Pins in, synchronised out
  input  wire [W-1:0] pin,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= pin;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/byte_pair_reg.v
// Purpose: 14-bit register written as two bytes, upper byte first
// Assumes: Lower-byte write commits the held upper byte
// Notes:   Internal load has priority over a host commit
`timescale 1ns/1ps
`default_nettype none

`include "fieldbus_status_config_regs.vh"

module byte_pair_reg (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Host byte writes
  input  wire [7:0]  wdata,
  input  wire        hi_we,
  input  wire        lo_we,
  // Internal update
  input  wire        load,
  input  wire [13:0] load_value,
  // Current value
  output reg  [13:0] value_q
);

  localparam [13:0] RST_VALUE = `POINTER_RST;

  reg [5:0] upper_q;

  always @(posedge clk) begin
    if (srst) begin
      upper_q <= RST_VALUE[13:8];
      value_q <= `POINTER_RST;
    end else begin
      if (hi_we) begin
        upper_q <= wdata[5:0];
      end
      // Never expose a half-written value downstream
      if (load) begin
        value_q <= load_value;
      end else if (lo_we) begin
        value_q <= {upper_q, wdata};
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/fieldbus_status_config_regs.v
// Purpose: Error flags, masks, DMA/lookup pointers, frame control and status bank
// Assumes: Host pins asynchronous to CLOCK; event inputs on CLOCK
// Notes:   Byte bus with active-low chip select and strobes
`timescale 1ns/1ps
`default_nettype none

`include "fieldbus_status_config_regs.vh"

module fieldbus_status_config_regs (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        SRST,
  // Host register bus
  input  wire [11:0] REG_ADDR,
  input  wire        REG_CS_N,
  input  wire        REG_WR_N,
  input  wire        REG_RD_N,
  input  wire [7:0]  DATA_IN,
  output reg  [7:0]  DATA_OUT,
  output wire        DATA_OE,
  // Error events
  input  wire        JABBER_EVENT,
  input  wire        TX_START_EMPTY_EVENT,
  input  wire        CARRIER_LOSS_EVENT,
  input  wire        OVERLENGTH_EVENT,
  input  wire        LINE_CODE_EVENT,
  input  wire        MISSING_END_DELIM_EVENT,
  input  wire        MISSING_START_DELIM_EVENT,
  // Live communication status
  input  wire        RX_BYTE_READY,
  input  wire        RX_CARRIER_ACTIVE,
  input  wire        RX_START_SEEN,
  input  wire        RX_OVERRUN,
  input  wire        RX_END_SEEN,
  input  wire        RX_CHECK_ERROR,
  input  wire        TX_IDLE,
  input  wire        TX_HOLDING_EMPTY,
  // Live address recognition status
  input  wire        HIGH_LINK_FRAME,
  input  wire        NODE_SELECT_FRAME,
  input  wire        STATION_ADDR_FRAME,
  input  wire        PSA_TYPE_FRAME,
  input  wire        FRAME_CONTROL_SEEN,
  input  wire        TABLE_END_REACHED,
  input  wire        ADDR_MATCHED,
  input  wire        BROADCAST_FRAME,
  // Frame control capture
  input  wire        FRAME_CONTROL_VALID,
  input  wire [7:0]  FRAME_CONTROL_OCTET,
  // Lookup and receive DMA updates
  input  wire        LOOKUP_DONE,
  input  wire [13:0] LOOKUP_NEXT,
  input  wire        RX_PTR_UPDATE,
  input  wire [13:0] RX_PTR_VALUE,
  // Interrupt status of the other groups
  input  wire [7:0]  COMM_IRQ_STATUS,
  input  wire [7:0]  ADDR_IRQ_STATUS,
  input  wire [7:0]  TIMER_IRQ_STATUS,
  // Configuration to DMA and address recognition
  output wire [13:0] TX_BYTE_COUNT,
  output wire [13:0] TX_BUFFER_POINTER,
  output wire [13:0] RX_BUFFER_POINTER,
  output wire [13:0] NODE_SELECT_TABLE_BASE,
  output wire [13:0] HIGH_LINK_TABLE_BASE,
  output wire [7:0]  STATION_IDENTIFIER,
  // Interrupt requests
  output reg         COMM_IRQ_REQ,
  output reg         ADDR_IRQ_REQ,
  output reg         TIMER_IRQ_REQ,
  output reg         ERROR_IRQ_REQ,
  output reg         ERROR_SUMMARY_FLAG
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  localparam NPAIR = 5;

  function addr_is;
    input [11:0] a;
    input [11:0] ofs;
    begin
      addr_is = (a == ofs);
    end
  endfunction

  function [11:0] pair_ofs;
    input integer i;
    begin
      case (i)
        0:       pair_ofs = `TX_BYTE_COUNT_OFS;
        1:       pair_ofs = `TX_BUFFER_POINTER_OFS;
        2:       pair_ofs = `RX_BUFFER_POINTER_OFS;
        3:       pair_ofs = `LOOKUP_POINTER_OFS;
        default: pair_ofs = `HIGH_LINK_TABLE_OFS;
      endcase
    end
  endfunction

  // Frame type code is the low five bits of the frame control octet, passed through as is
  function [4:0] frame_type;
    input [7:0] fc;
    begin
      frame_type = fc[4:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Host pin synchronisation
  // ------------------------------------------------------------
  wire [11:0] addr_s;
  wire [7:0]  wdata_s;
  wire        cs_s;
  wire        wr_s;
  wire        rd_s;
  reg         wr_act_q;

  pin_sync #(
    .W (23)
  ) u_pin_sync (
    .clk  (CLOCK),
    .srst (SRST),
    .pin  ({REG_ADDR, DATA_IN, ~REG_CS_N, ~REG_WR_N, ~REG_RD_N}),
    .q    ({addr_s, wdata_s, cs_s, wr_s, rd_s})
  );

  wire wr_act   = cs_s & wr_s;
  wire rd_act   = cs_s & rd_s;
  // One write per strobe, however long the host holds it
  wire wr_pulse = wr_act & ~wr_act_q;

  always @(posedge CLOCK) begin
    if (SRST) begin
      wr_act_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
    end
  end

  // ------------------------------------------------------------
  // Byte-paired pointer and count registers
  // ------------------------------------------------------------
  wire [14*NPAIR-1:0] pair_flat;
  wire [NPAIR-1:0]    pair_load = {2'b00, RX_PTR_UPDATE, 2'b00};
  wire [14*NPAIR-1:0] pair_load_val = {28'h0000000, RX_PTR_VALUE, 28'h0000000};

  genvar g;
  generate
    for (g = 0; g < NPAIR; g = g + 1) begin : pairs
      byte_pair_reg u_pair (
        .clk        (CLOCK),
        .srst       (SRST),
        .wdata      (wdata_s),
        .hi_we      (wr_pulse & addr_is(addr_s, pair_ofs(g) + 12'h001)),
        .lo_we      (wr_pulse & addr_is(addr_s, pair_ofs(g))),
        .load       (pair_load[g]),
        .load_value (pair_load_val[14*g +: 14]),
        .value_q    (pair_flat[14*g +: 14])
      );
    end
  endgenerate

  assign TX_BYTE_COUNT          = pair_flat[13:0];
  assign TX_BUFFER_POINTER      = pair_flat[27:14];
  assign RX_BUFFER_POINTER      = pair_flat[41:28];
  assign NODE_SELECT_TABLE_BASE = pair_flat[55:42];
  assign HIGH_LINK_TABLE_BASE   = pair_flat[69:56];

  // ------------------------------------------------------------
  // Masks and station identifier
  // ------------------------------------------------------------
  reg [7:0] comm_irq_mask_q;
  reg [7:0] addr_irq_mask_q;
  reg [7:0] timer_irq_mask_q;
  reg [7:0] error_irq_mask_q;
  reg [7:0] station_identifier_q;

  always @(posedge CLOCK) begin
    if (SRST) begin
      comm_irq_mask_q      <= `MASK_RST;
      addr_irq_mask_q      <= `MASK_RST;
      timer_irq_mask_q     <= `MASK_RST;
      error_irq_mask_q     <= `MASK_RST;
      station_identifier_q <= `STATION_ID_RST;
    end else if (wr_pulse) begin
      if (addr_is(addr_s, `COMM_IRQ_MASK_OFS)) begin
        comm_irq_mask_q <= wdata_s;
      end
      if (addr_is(addr_s, `ADDR_IRQ_MASK_OFS)) begin
        addr_irq_mask_q <= wdata_s;
      end
      if (addr_is(addr_s, `TIMER_IRQ_MASK_OFS)) begin
        timer_irq_mask_q <= wdata_s;
      end
      if (addr_is(addr_s, `ERROR_IRQ_MASK_OFS)) begin
        error_irq_mask_q <= wdata_s;
      end
      if (addr_is(addr_s, `STATION_ID_OFS)) begin
        station_identifier_q <= wdata_s;
      end
    end
  end

  assign STATION_IDENTIFIER = station_identifier_q;

  // ------------------------------------------------------------
  // Error interrupt status, write one to clear
  // ------------------------------------------------------------
  reg  [6:0] error_irq_status_q;
  reg  [6:0] error_irq_status_d;
  wire [6:0] err_set;
  wire [6:0] err_clr;

  assign err_set[`JABBER_BIT]         = JABBER_EVENT;
  assign err_set[`TX_START_EMPTY_BIT] = TX_START_EMPTY_EVENT;
  assign err_set[`CARRIER_LOSS_BIT]   = CARRIER_LOSS_EVENT;
  assign err_set[`OVERLENGTH_BIT]     = OVERLENGTH_EVENT;
  assign err_set[`LINE_CODE_BIT]      = LINE_CODE_EVENT;
  assign err_set[`MISSING_END_BIT]    = MISSING_END_DELIM_EVENT;
  assign err_set[`MISSING_START_BIT]  = MISSING_START_DELIM_EVENT;

  assign err_clr = (wr_pulse & addr_is(addr_s, `ERROR_IRQ_STATUS_OFS)) ?
                   wdata_s[`ERROR_FLAG_MSB:0] : 7'h00;

  always @* begin
    // Set beats clear so an event in the clearing cycle survives
    error_irq_status_d = (error_irq_status_q & ~err_clr) | err_set;
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      error_irq_status_q <= `ERROR_STATUS_RST;
    end else begin
      error_irq_status_q <= error_irq_status_d;
    end
  end

  // ------------------------------------------------------------
  // Interrupt requests
  // ------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (SRST) begin
      COMM_IRQ_REQ       <= 1'b0;
      ADDR_IRQ_REQ       <= 1'b0;
      TIMER_IRQ_REQ      <= 1'b0;
      ERROR_IRQ_REQ      <= 1'b0;
      ERROR_SUMMARY_FLAG <= 1'b0;
    end else begin
      COMM_IRQ_REQ       <= |(COMM_IRQ_STATUS & comm_irq_mask_q);
      ADDR_IRQ_REQ       <= |(ADDR_IRQ_STATUS & addr_irq_mask_q);
      TIMER_IRQ_REQ      <= |(TIMER_IRQ_STATUS & timer_irq_mask_q);
      // Masking gates the request only, never the flag
      ERROR_IRQ_REQ      <= |(error_irq_status_q & error_irq_mask_q[6:0]);
      ERROR_SUMMARY_FLAG <= |error_irq_status_q;
    end
  end

  // ------------------------------------------------------------
  // Frame control capture and lookup pointer
  // ------------------------------------------------------------
  reg [7:0]  frame_control_word_q;
  reg [4:0]  frame_type_code_q;
  reg [13:0] lookup_next_pointer_q;

  always @(posedge CLOCK) begin
    if (SRST) begin
      frame_control_word_q  <= `FRAME_CONTROL_RST;
      frame_type_code_q     <= `FRAME_CODE_RST;
      lookup_next_pointer_q <= `POINTER_RST;
    end else begin
      if (FRAME_CONTROL_VALID) begin
        frame_control_word_q <= FRAME_CONTROL_OCTET;
        frame_type_code_q    <= frame_type(FRAME_CONTROL_OCTET);
      end
      if (LOOKUP_DONE) begin
        lookup_next_pointer_q <= LOOKUP_NEXT;
      end
    end
  end

  // ------------------------------------------------------------
  // Live status words
  // ------------------------------------------------------------
  wire [7:0] comm_status = {RX_BYTE_READY, RX_CARRIER_ACTIVE, RX_START_SEEN,
                            RX_OVERRUN, RX_END_SEEN, RX_CHECK_ERROR,
                            TX_IDLE, TX_HOLDING_EMPTY};
  wire [7:0] addr_recog_status = {HIGH_LINK_FRAME, NODE_SELECT_FRAME,
                                  STATION_ADDR_FRAME, PSA_TYPE_FRAME,
                                  FRAME_CONTROL_SEEN, TABLE_END_REACHED,
                                  ADDR_MATCHED, BROADCAST_FRAME};

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (addr_s)
      `ERROR_IRQ_STATUS_OFS:           rd_mux = {1'b0, error_irq_status_q};
      `COMM_IRQ_MASK_OFS:              rd_mux = comm_irq_mask_q;
      `ADDR_IRQ_MASK_OFS:              rd_mux = addr_irq_mask_q;
      `TIMER_IRQ_MASK_OFS:             rd_mux = timer_irq_mask_q;
      `ERROR_IRQ_MASK_OFS:             rd_mux = error_irq_mask_q;
      `TX_BYTE_COUNT_OFS:              rd_mux = TX_BYTE_COUNT[7:0];
      `TX_BYTE_COUNT_OFS + 12'h001:    rd_mux = {2'b00, TX_BYTE_COUNT[13:8]};
      `TX_BUFFER_POINTER_OFS:          rd_mux = TX_BUFFER_POINTER[7:0];
      `TX_BUFFER_POINTER_OFS + 12'h001: rd_mux = {2'b00, TX_BUFFER_POINTER[13:8]};
      `RX_BUFFER_POINTER_OFS:          rd_mux = RX_BUFFER_POINTER[7:0];
      `RX_BUFFER_POINTER_OFS + 12'h001: rd_mux = {2'b00, RX_BUFFER_POINTER[13:8]};
      // Table bases are write-only; reads at the node select base see the lookup pointer, at the high link base frame control
      `LOOKUP_POINTER_OFS:             rd_mux = lookup_next_pointer_q[7:0];
      `LOOKUP_POINTER_OFS + 12'h001:   rd_mux = {2'b00, lookup_next_pointer_q[13:8]};
      `FRAME_CONTROL_OFS:              rd_mux = frame_control_word_q;
      `FRAME_TYPE_CODE_OFS:            rd_mux = {3'b000, frame_type_code_q};
      `STATION_ID_OFS:                 rd_mux = station_identifier_q;
      `COMM_STATUS_OFS:                rd_mux = comm_status;
      `ADDR_RECOG_STATUS_OFS:          rd_mux = addr_recog_status;
      default:                         rd_mux = `UNMAPPED_READ;
    endcase
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      DATA_OUT <= 8'h00;
    end else if (rd_act) begin
      DATA_OUT <= rd_mux;
    end
  end

  // Drive only while the host reads; data trails enable by one cycle
  assign DATA_OE = rd_act;

endmodule

`default_nettype wire

// ===== sim/fieldbus_regs_assertions.sv
// Purpose: Port-level timing checks for the status/config bank
// Assumes: One CLOCK domain, SRST synchronous active high
// Notes:   Write-quiet counter hides the host write latency
`timescale 1ns/1ps
`default_nettype none
module fieldbus_regs_checker (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SRST,
  // Host bus
  input wire logic        REG_CS_N,
  input wire logic        REG_WR_N,
  input wire logic        REG_RD_N,
  input wire logic        DATA_OE,
  // Events and loads
  input wire logic        JABBER_EVENT,
  input wire logic        RX_PTR_UPDATE,
  input wire logic [13:0] RX_PTR_VALUE,
  input wire logic [7:0]  COMM_IRQ_STATUS,
  // Bank outputs
  input wire logic [13:0] TX_BYTE_COUNT,
  input wire logic [13:0] RX_BUFFER_POINTER,
  input wire logic [13:0] NODE_SELECT_TABLE_BASE,
  input wire logic [7:0]  STATION_IDENTIFIER,
  input wire logic        COMM_IRQ_REQ,
  input wire logic        ERROR_IRQ_REQ,
  input wire logic        ERROR_SUMMARY_FLAG
);
  // ------------------------------------------------------------
  // Cycles since the last write strobe
  // ------------------------------------------------------------
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  logic       quiet;
  assign quiet_d = (!REG_CS_N && !REG_WR_N) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
  assign quiet   = quiet_q >= 3'h5;
  always @(posedge CLOCK) begin
    quiet_q <= SRST ? 3'h0 : quiet_d;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  jabber_summary_a: assert property (JABBER_EVENT |-> ##[1:2] ERROR_SUMMARY_FLAG)
    else $error("jabber event left summary low");
  summary_sticky_a: assert property (ERROR_SUMMARY_FLAG && quiet |=> ERROR_SUMMARY_FLAG)
    else $error("summary dropped without a write");
  req_needs_flag_a: assert property (ERROR_IRQ_REQ |-> ERROR_SUMMARY_FLAG)
    else $error("error request with no flag");
  comm_req_quiet_a: assert property ($past(COMM_IRQ_STATUS) == 8'h00 |-> !COMM_IRQ_REQ)
    else $error("comm request with no status bit");
  oe_after_read_a: assert property ($rose(DATA_OE) |->
    $past(REG_CS_N, 2) == 1'b0 && $past(REG_RD_N, 2) == 1'b0)
    else $error("read drive without a read strobe");
  oe_idle_a: assert property (REG_CS_N && $past(REG_CS_N) && $past(REG_CS_N, 2) |-> !DATA_OE)
    else $error("read drive while deselected");
  rx_load_a: assert property (RX_PTR_UPDATE |=> RX_BUFFER_POINTER == $past(RX_PTR_VALUE))
    else $error("receive pointer load lost");
  rx_ptr_hold_a: assert property (quiet && !$past(RX_PTR_UPDATE) |-> $stable(RX_BUFFER_POINTER))
    else $error("receive pointer moved on its own");
  config_hold_a: assert property (quiet |->
    $stable({TX_BYTE_COUNT, NODE_SELECT_TABLE_BASE, STATION_IDENTIFIER}))
    else $error("configuration moved without a write");
  cover property (JABBER_EVENT);
  cover property (ERROR_IRQ_REQ);
  cover property ($rose(DATA_OE));
endmodule
bind fieldbus_status_config_regs fieldbus_regs_checker chk (
  .CLOCK(CLOCK), .SRST(SRST), .REG_CS_N(REG_CS_N), .REG_WR_N(REG_WR_N),
  .REG_RD_N(REG_RD_N), .DATA_OE(DATA_OE), .JABBER_EVENT(JABBER_EVENT),
  .RX_PTR_UPDATE(RX_PTR_UPDATE), .RX_PTR_VALUE(RX_PTR_VALUE),
  .COMM_IRQ_STATUS(COMM_IRQ_STATUS), .TX_BYTE_COUNT(TX_BYTE_COUNT),
  .RX_BUFFER_POINTER(RX_BUFFER_POINTER), .NODE_SELECT_TABLE_BASE(NODE_SELECT_TABLE_BASE),
  .STATION_IDENTIFIER(STATION_IDENTIFIER), .COMM_IRQ_REQ(COMM_IRQ_REQ),
  .ERROR_IRQ_REQ(ERROR_IRQ_REQ), .ERROR_SUMMARY_FLAG(ERROR_SUMMARY_FLAG)
);
`default_nettype wire

// ===== sim/host_cpu_model.sv
// Purpose: Host CPU model driving the byte-wide register bus
// Assumes: Pins move on the falling edge of the clock
// Notes:   Released data pins carry the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  // Clock
  input  wire logic        clk,
  // Register bus
  output var  logic [11:0] addr,
  output var  logic        cs_n,
  output var  logic        wr_n,
  output var  logic        rd_n,
  output var  logic [7:0]  wdata,
  input  wire logic [7:0]  rdata,
  input  wire logic        oe
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  int hangs = 0;
  int slow  = 0;
  initial begin
    addr  = 12'h000;
    cs_n  = 1'b1;
    wr_n  = 1'b1;
    rd_n  = 1'b1;
    wdata = 8'hff;
  end
  // Hold spans the synchroniser plus the commit edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    cs_n  = 1'b0;
    wr_n  = 1'b0;
    repeat (4 + slow) @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (3) @(negedge clk);
    wdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    while (oe !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      hangs++;
      $display("MISMATCH %0t read strobe never answered", $time);
    end
    repeat (1 + slow) @(negedge clk);
    d    = rdata;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  // Upper byte first; the lower byte commits the pair
  task automatic wr16(input logic [11:0] base, input logic [13:0] v);
    wr(base + 12'h001, {2'b00, v[13:8]});
    wr(base, v[7:0]);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the status/config register bank
// Assumes: Host model owns the bus pins; bench owns all event inputs
// Notes:   Table rows cover read-back, a read-only status and an unmapped offset; edge cases follow by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        srst, fc_v, lk_v, rp_v;
  logic [6:0]  ev;
  logic [7:0]  cs_v, as_v, cis, ais, tis, fc_o, r;
  logic [13:0] lk_n, rp_n;
  wire  [11:0] addr;
  wire  [7:0]  wdata, rdata, sid;
  wire         cs_n, wr_n, rd_n, oe, sum;
  wire  [3:0]  req;
  wire  [13:0] tx_cnt, tx_ptr, rx_ptr, ns_base, hl_base;
  int          errors = 0;
  int          n_tests = 0;
  typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  row_t rows [7] = '{'{12'h008, 8'ha5, 8'ha5}, '{12'h009, 8'h5a, 8'h5a},
    '{12'h00a, 8'hc3, 8'hc3}, '{12'h00b, 8'hbc, 8'hbc}, '{12'h01b, 8'h7e, 8'h7e},
    '{12'h01c, 8'hff, 8'h00}, '{12'h01a, 8'h55, 8'h00}};
  always #25 clk = ~clk;
  host_cpu_model host (.clk(clk), .addr(addr), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .wdata(wdata), .rdata(rdata), .oe(oe));
  fieldbus_status_config_regs DUT (.CLOCK(clk), .SRST(srst), .REG_ADDR(addr),
    .REG_CS_N(cs_n), .REG_WR_N(wr_n), .REG_RD_N(rd_n), .DATA_IN(wdata),
    .DATA_OUT(rdata), .DATA_OE(oe), .JABBER_EVENT(ev[6]), .TX_START_EMPTY_EVENT(ev[5]),
    .CARRIER_LOSS_EVENT(ev[4]), .OVERLENGTH_EVENT(ev[3]), .LINE_CODE_EVENT(ev[2]),
    .MISSING_END_DELIM_EVENT(ev[1]), .MISSING_START_DELIM_EVENT(ev[0]),
    .RX_BYTE_READY(cs_v[7]), .RX_CARRIER_ACTIVE(cs_v[6]), .RX_START_SEEN(cs_v[5]),
    .RX_OVERRUN(cs_v[4]), .RX_END_SEEN(cs_v[3]), .RX_CHECK_ERROR(cs_v[2]),
    .TX_IDLE(cs_v[1]), .TX_HOLDING_EMPTY(cs_v[0]), .HIGH_LINK_FRAME(as_v[7]),
    .NODE_SELECT_FRAME(as_v[6]), .STATION_ADDR_FRAME(as_v[5]), .PSA_TYPE_FRAME(as_v[4]),
    .FRAME_CONTROL_SEEN(as_v[3]), .TABLE_END_REACHED(as_v[2]), .ADDR_MATCHED(as_v[1]),
    .BROADCAST_FRAME(as_v[0]), .FRAME_CONTROL_VALID(fc_v), .FRAME_CONTROL_OCTET(fc_o),
    .LOOKUP_DONE(lk_v), .LOOKUP_NEXT(lk_n), .RX_PTR_UPDATE(rp_v), .RX_PTR_VALUE(rp_n),
    .COMM_IRQ_STATUS(cis), .ADDR_IRQ_STATUS(ais), .TIMER_IRQ_STATUS(tis),
    .TX_BYTE_COUNT(tx_cnt), .TX_BUFFER_POINTER(tx_ptr), .RX_BUFFER_POINTER(rx_ptr),
    .NODE_SELECT_TABLE_BASE(ns_base), .HIGH_LINK_TABLE_BASE(hl_base),
    .STATION_IDENTIFIER(sid), .COMM_IRQ_REQ(req[3]), .ADDR_IRQ_REQ(req[2]),
    .TIMER_IRQ_REQ(req[1]), .ERROR_IRQ_REQ(req[0]), .ERROR_SUMMARY_FLAG(sum));
  task automatic end_of_test;
    errors += host.hangs;
    $display("Counts: %0d mismatches in %0d comparisons", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_of_test;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {srst, ev, cs_v, as_v, cis, ais, tis, fc_v, fc_o} = {1'b1, 56'h0};
    {lk_v, lk_n, rp_v, rp_n} = 30'h0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    `CHK({tx_cnt, rx_ptr, ns_base, sid, req, sum}, 55'h0)
    foreach (rows[i]) begin
      host.slow = i % 2;
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, r);
      `CHK(r, rows[i].e)
    end
    host.slow = 0;
    `CHK(sid, 8'h7e)
    host.wr(12'h00d, 8'h2a);
    `CHK(tx_cnt, 14'h0000)
    host.wr(12'h00c, 8'h5b);
    `CHK(tx_cnt, 14'h2a5b)
    host.rd(12'h00d, r);
    `CHK(r, 8'h2a)
    host.wr16(12'h00e, 14'h3fff);
    host.wr16(12'h012, 14'h2001);
    host.wr16(12'h016, 14'h1234);
    host.wr16(12'h018, 14'h0abc);
    `CHK({tx_ptr, rx_ptr, ns_base, hl_base}, {14'h3fff, 14'h2001, 14'h1234, 14'h0abc})
    rp_n = 14'h0155;
    rp_v = 1'b1;
    lk_n = 14'h1abc;
    lk_v = 1'b1;
    @(negedge clk);
    {rp_v, lk_v} = 2'b00;
    `CHK(rx_ptr, 14'h0155)
    host.rd(12'h016, r);
    `CHK(r, 8'hbc)
    host.rd(12'h017, r);
    `CHK(r, 8'h1a)
    as_v = 8'h08;
    for (int i = 0; i < 32; i++) begin
      fc_o = {i[2:0], i[4:0]};
      fc_v = 1'b1;
      @(negedge clk);
      fc_v = 1'b0;
      host.rd(12'h018, r);
      `CHK(r, fc_o)
      host.rd(12'h019, r);
      `CHK(r, {3'b000, fc_o[4:0]})
    end
    host.wr(12'h00b, 8'h00);
    for (int b = 0; b < 7; b++) begin
      ev[b] = 1'b1;
      @(negedge clk);
      ev[b] = 1'b0;
      repeat (2) @(negedge clk);
      `CHK({sum, req[0]}, 2'b10)
      host.rd(12'h007, r);
      `CHK(r, 8'h01 << b)
      host.wr(12'h007, 8'h01 << b);
      `CHK(sum, 1'b0)
    end
    host.wr(12'h00b, 8'h40);
    ev[6] = 1'b1;
    @(negedge clk);
    ev[6] = 1'b0;
    host.wr(12'h007, 8'h01);
    `CHK({sum, req[0]}, 2'b11)
    host.wr(12'h007, 8'h40);
    `CHK(req[0], 1'b0)
    {cis, ais, tis} = {3{8'h81}};
    host.wr(12'h008, 8'h80);
    host.wr(12'h009, 8'h01);
    host.wr(12'h00a, 8'h7e);
    `CHK(req[3:1], 3'b110)
    for (int k = 0; k < 2; k++) begin
      cs_v = k ? 8'h4b : 8'hb4;
      as_v = ~cs_v;
      host.rd(12'h01c, r);
      `CHK(r, cs_v)
      host.rd(12'h01d, r);
      `CHK(r, as_v)
    end
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    host.rd(12'h008, r);
    `CHK({r, sid, tx_cnt, sum}, 31'h0)
    end_of_test;
  end
endmodule
`default_nettype wire
